/* File: rtl/dtc_defs.svh */
`ifndef DTC_DEFS_SVH
`define DTC_DEFS_SVH

// ------------------------------------------------------------------
// register offsets (byte addresses, low 12 bits of haddr)
// ------------------------------------------------------------------
`define DTC_OFS_STATUS      12'h000
`define DTC_OFS_ENABLE      12'h004
`define DTC_OFS_CLEAR       12'h008
`define DTC_OFS_DETAIL      12'h00C
`define DTC_OFS_COMMAND     12'h010
`define DTC_OFS_PACING      12'h014

// ------------------------------------------------------------------
// error status / enable / clear layout
// ------------------------------------------------------------------
`define DTC_BIT_BUS_FAULT   0
`define DTC_BIT_REQ_FAULT   2
`define DTC_BIT_MAP_FAULT   3
`define DTC_ERR_MASK        4'hD
`define DTC_ERR_RESET       4'h0

// ------------------------------------------------------------------
// error detail layout
// ------------------------------------------------------------------
`define DTC_DET_STAT_LSB    0
`define DTC_DET_TCC_LSB     8
`define DTC_DET_IRQEN_BIT   16
`define DTC_DET_CHAIN_BIT   17
`define DTC_STAT_NONE       4'h0
`define DTC_TCC_RESET       6'h00

// ------------------------------------------------------------------
// command and pacing fields
// ------------------------------------------------------------------
`define DTC_CMD_ERROR_REEVALUATE_BIT    0
`define DTC_PACE_RESET      3'h0
`define DTC_GAP_FULL        6'h01
`define DTC_GAP_4           6'h04
`define DTC_GAP_8           6'h08
`define DTC_GAP_16          6'h10
`define DTC_GAP_32          6'h20
`define DTC_WORD_ZERO       32'h0000_0000

`endif

/* File: rtl/dtc_pkg.sv */
package dtc_pkg;

    typedef enum logic [2:0] {
        DTC_RATE_FULL = 3'b000,
        DTC_RATE_4    = 3'b001,
        DTC_RATE_8    = 3'b010,
        DTC_RATE_16   = 3'b011,
        DTC_RATE_32   = 3'b100
    } dtc_rate_t;

    typedef struct packed {
        logic       chain_en;
        logic       irq_en;
        logic [5:0] completion_code;
        logic [3:0] stat;
    } dtc_detail_t;

endpackage

/* File: rtl/dtc_err_if.sv */
`timescale 1ns/1ps

interface dtc_err_if;
    import dtc_pkg::*;

    logic        fault;
    logic        clear;
    dtc_detail_t detail;

    modport cap (output fault, output detail, input clear);
    modport reg_side (input fault, input detail, output clear);
endinterface

/* File: rtl/dtc_capture.sv */
`timescale 1ns/1ps
`include "dtc_defs.svh"

module dtc_capture
    import dtc_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       arst_n_i,
    input  wire logic [3:0] rd_status_i,
    input  wire logic [5:0] rd_tcc_i,
    input  wire logic       rd_irq_en_i,
    input  wire logic       rd_chain_en_i,
    input  wire logic [3:0] wr_status_i,
    input  wire logic [5:0] wr_tcc_i,
    input  wire logic       wr_irq_en_i,
    input  wire logic       wr_chain_en_i,
    dtc_err_if.cap          err
);

    dtc_detail_t detail;
    dtc_detail_t next_detail;
    wire logic   wr_hit;
    wire logic   rd_hit;

    // ------------------------------------------------------------------
    // source select
    // ------------------------------------------------------------------
    assign wr_hit = (wr_status_i != `DTC_STAT_NONE);
    assign rd_hit = (rd_status_i != `DTC_STAT_NONE);

    always_comb begin
        next_detail = detail;
        if (wr_hit) begin
            next_detail.stat     = wr_status_i;
            next_detail.completion_code      = wr_tcc_i;
            next_detail.irq_en   = wr_irq_en_i;
            next_detail.chain_en = wr_chain_en_i;
        end else if (rd_hit) begin
            next_detail.stat     = rd_status_i;
            next_detail.completion_code      = rd_tcc_i;
            next_detail.irq_en   = rd_irq_en_i;
            next_detail.chain_en = rd_chain_en_i;
        end else if (err.clear) begin
            next_detail = '0;
        end
    end

    // ------------------------------------------------------------------
    // detail register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            detail <= '0;
        end else begin
            detail <= next_detail;
        end
    end

    assign err.fault  = wr_hit | rd_hit;
    assign err.detail = detail;

endmodule

/* File: rtl/dtc_pacer.sv */
`timescale 1ns/1ps
`include "dtc_defs.svh"

module dtc_pacer
    import dtc_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       arst_n_i,
    input  wire logic [2:0] rate_i,
    input  wire logic       req_i,
    output logic            go_o
);

    logic [5:0] wait_cnt;
    logic [5:0] gap;
    wire logic  next_go;

    // ------------------------------------------------------------------
    // spacing decode
    // ------------------------------------------------------------------
    always_comb begin
        case (dtc_rate_t'(rate_i))
            DTC_RATE_4:  gap = `DTC_GAP_4;
            DTC_RATE_8:  gap = `DTC_GAP_8;
            DTC_RATE_16: gap = `DTC_GAP_16;
            DTC_RATE_32: gap = `DTC_GAP_32;
            default:     gap = `DTC_GAP_FULL;
        endcase
    end

    // ------------------------------------------------------------------
    // issue spacing
    // ------------------------------------------------------------------
    assign next_go = req_i & (wait_cnt == 6'h00);

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wait_cnt <= 6'h00;
            go_o     <= 1'b0;
        end else begin
            go_o <= next_go;
            if (next_go) begin
                wait_cnt <= gap - 6'h01;
            end else if (wait_cnt != 6'h00) begin
                wait_cnt <= wait_cnt - 6'h01;
            end
        end
    end

endmodule

/* File: rtl/dtc_top.sv */
// Chosen here: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`include "dtc_defs.svh"

// How it works
// - a nonzero status code is stored in bits 3-0; 1-7 read, 8-F write
// - if only one of read and write status is nonzero, that one is stored
// - if both are nonzero at once, the write status wins
// - bits 13-8 hold the completion code of the failing transfer
// - bit 16 holds the completion interrupt enable of the failing transfer
// - bit 17 holds the completion chaining enable of the failing transfer
// - writing 1 to command bit 0 pulses the error line if any status set
// - read commands wait the programmed gap, within and across requests
// - pacing field 0 full speed; 1-4 give 4, 8, 16, 32 cycles
// - a gap of N cycles means reads start N cycles apart
// - one pacing setting serves every read command request
// - detail register is read-only and zero after reset
// - clearing bus fault clears the detail; other clears leave it
// - a status bit set with its enable set raises the error interrupt
module dtc_top
    import dtc_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,
    // ahb-lite slave
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic        hready_i,
    input  wire logic [31:0] hwdata_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    // transaction status and options
    input  wire logic [3:0]  rd_status_i,
    input  wire logic [5:0]  rd_tcc_i,
    input  wire logic        rd_irq_en_i,
    input  wire logic        rd_chain_en_i,
    input  wire logic [3:0]  wr_status_i,
    input  wire logic [5:0]  wr_tcc_i,
    input  wire logic        wr_irq_en_i,
    input  wire logic        wr_chain_en_i,
    input  wire logic        request_fault_i,
    // read command pacing
    input  wire logic        rd_cmd_req_i,
    output logic             rd_cmd_go_o,
    // error line
    output logic             err_irq_o,
    output logic             err_error_reevaluate_pulse_o
);

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    dtc_err_if   err ();

    logic        dp_valid;
    logic        dp_write;
    logic [11:0] dp_addr;
    logic [3:0]  err_status;
    logic [3:0]  err_enable;
    logic [2:0]  read_pacing;
    logic [3:0]  next_status;
    logic [3:0]  set_bits;
    logic [31:0] rd_mux;
    logic [31:0] detail_word;

    wire logic        ap_take;
    wire logic [11:0] ap_ofs;
    wire logic        ap_mapped;
    wire logic        map_fault_ev;
    wire logic        wr_en;
    wire logic        wr_enable;
    wire logic        wr_clear;
    wire logic        wr_command;
    wire logic        wr_pacing;
    wire logic [3:0]  clr_bits;
    wire logic        error_reevaluate_hit;

    // ------------------------------------------------------------------
    // ahb address phase decode
    // ------------------------------------------------------------------
    assign ap_take = hsel_i & htrans_i[1] & hready_i;
    assign ap_ofs  = haddr_i[11:0];

    assign ap_mapped = (ap_ofs == `DTC_OFS_STATUS)  ||
                       (ap_ofs == `DTC_OFS_ENABLE)  ||
                       (ap_ofs == `DTC_OFS_CLEAR)   ||
                       (ap_ofs == `DTC_OFS_DETAIL)  ||
                       (ap_ofs == `DTC_OFS_COMMAND) ||
                       (ap_ofs == `DTC_OFS_PACING);

    assign map_fault_ev = ap_take & ~ap_mapped;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            dp_valid <= 1'b0;
            dp_write <= 1'b0;
            dp_addr  <= 12'h000;
        end else if (hready_i) begin
            dp_valid <= ap_take;
            dp_write <= hwrite_i;
            dp_addr  <= ap_ofs;
        end
    end

    // ------------------------------------------------------------------
    // data phase write strobes
    // ------------------------------------------------------------------
    assign wr_en      = dp_valid & dp_write;
    assign wr_enable  = wr_en & (dp_addr == `DTC_OFS_ENABLE);
    assign wr_clear   = wr_en & (dp_addr == `DTC_OFS_CLEAR);
    assign wr_command = wr_en & (dp_addr == `DTC_OFS_COMMAND);
    assign wr_pacing  = wr_en & (dp_addr == `DTC_OFS_PACING);

    assign clr_bits = wr_clear ? (hwdata_i[3:0] & `DTC_ERR_MASK) : 4'h0;

    // bit 1 of the command word is left without effect
    assign error_reevaluate_hit = wr_command & hwdata_i[`DTC_CMD_ERROR_REEVALUATE_BIT];

    // ------------------------------------------------------------------
    // read data mux
    // ------------------------------------------------------------------
    always_comb begin
        detail_word = `DTC_WORD_ZERO;
        detail_word[`DTC_DET_STAT_LSB +: 4]  = err.detail.stat;
        detail_word[`DTC_DET_TCC_LSB +: 6]   = err.detail.completion_code;
        detail_word[`DTC_DET_IRQEN_BIT]      = err.detail.irq_en;
        detail_word[`DTC_DET_CHAIN_BIT]      = err.detail.chain_en;
    end

    always_comb begin
        rd_mux = `DTC_WORD_ZERO;
        if (ap_ofs == `DTC_OFS_STATUS) begin
            rd_mux[3:0] = err_status;
        end else if (ap_ofs == `DTC_OFS_ENABLE) begin
            rd_mux[3:0] = err_enable;
        end else if (ap_ofs == `DTC_OFS_DETAIL) begin
            rd_mux = detail_word;
        end else if (ap_ofs == `DTC_OFS_PACING) begin
            rd_mux[2:0] = read_pacing;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            hrdata_o <= `DTC_WORD_ZERO;
        end else if (ap_take && !hwrite_i) begin
            hrdata_o <= rd_mux;
        end else if (hready_i) begin
            hrdata_o <= `DTC_WORD_ZERO;
        end
    end

    // ------------------------------------------------------------------
    // bus response: zero wait, always okay
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end else begin
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // error capture
    // ------------------------------------------------------------------
    assign err.clear = clr_bits[`DTC_BIT_BUS_FAULT];

    dtc_capture u_capture (
        .clk_i         (clk_i),
        .arst_n_i      (arst_n_i),
        .rd_status_i   (rd_status_i),
        .rd_tcc_i      (rd_tcc_i),
        .rd_irq_en_i   (rd_irq_en_i),
        .rd_chain_en_i (rd_chain_en_i),
        .wr_status_i   (wr_status_i),
        .wr_tcc_i      (wr_tcc_i),
        .wr_irq_en_i   (wr_irq_en_i),
        .wr_chain_en_i (wr_chain_en_i),
        .err           (err.cap)
    );

    // ------------------------------------------------------------------
    // error status: set wins over clear
    // ------------------------------------------------------------------
    always_comb begin
        set_bits = 4'h0;
        set_bits[`DTC_BIT_BUS_FAULT] = err.fault;
        set_bits[`DTC_BIT_REQ_FAULT] = request_fault_i;
        set_bits[`DTC_BIT_MAP_FAULT] = map_fault_ev;
    end

    assign next_status = (set_bits | (err_status & ~clr_bits)) & `DTC_ERR_MASK;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            err_status <= `DTC_ERR_RESET;
        end else begin
            err_status <= next_status;
        end
    end

    // ------------------------------------------------------------------
    // error enable
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            err_enable <= `DTC_ERR_RESET;
        end else if (wr_enable) begin
            err_enable <= hwdata_i[3:0] & `DTC_ERR_MASK;
        end
    end

    // ------------------------------------------------------------------
    // error line: level interrupt and evaluate pulse
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            err_irq_o <= 1'b0;
        end else begin
            err_irq_o <= |(err_status & err_enable);
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            err_error_reevaluate_pulse_o <= 1'b0;
        end else begin
            err_error_reevaluate_pulse_o <= error_reevaluate_hit & (|err_status);
        end
    end

    // ------------------------------------------------------------------
    // read pacing
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            read_pacing <= `DTC_PACE_RESET;
        end else if (wr_pacing) begin
            read_pacing <= hwdata_i[2:0];
        end
    end

    dtc_pacer u_pacer (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .rate_i   (read_pacing),
        .req_i    (rd_cmd_req_i),
        .go_o     (rd_cmd_go_o)
    );

endmodule

/* File: dv/dtc_top_monitor.sv */
`timescale 1ns/1ps
`include "dtc_defs.svh"

module dtc_top_monitor (
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic        hready_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic [31:0] hrdata_o,
    input  wire logic        hreadyout_o,
    input  wire logic        hresp_o,
    input  wire logic        rd_cmd_req_i,
    input  wire logic        rd_cmd_go_o,
    input  wire logic        err_irq_o,
    input  wire logic        err_error_reevaluate_pulse_o
);
    // ----------------------------------------
    // data phase tracking and pacing shadow
    // ----------------------------------------
    logic        dp_wr;
    logic        dp_rd;
    logic [11:0] dp_ad;
    logic [2:0]  pace;
    logic [5:0]  since;
    logic [5:0]  held;
    wire  logic  ap     = hsel_i & htrans_i[1] & hready_i;
    wire  logic  wr_cmd = dp_wr & (dp_ad == `DTC_OFS_COMMAND) & hwdata_i[0];
    wire  logic  wr_irq = dp_wr & (dp_ad == `DTC_OFS_CLEAR | dp_ad == `DTC_OFS_ENABLE);
    wire  logic [5:0] gap_n = (pace == 3'h1) ? `DTC_GAP_4 : (pace == 3'h2) ? `DTC_GAP_8 :
                              (pace == 3'h3) ? `DTC_GAP_16 : (pace == 3'h4) ? `DTC_GAP_32 :
                              `DTC_GAP_FULL;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            {dp_wr, dp_rd, dp_ad, pace} <= '0;
            since <= 6'h3F;
            held  <= `DTC_GAP_FULL;
        end else begin
            if (rd_cmd_go_o) held <= gap_n;
            dp_wr <= ap & hwrite_i;
            dp_rd <= ap & ~hwrite_i;
            dp_ad <= haddr_i[11:0];
            if (dp_wr && dp_ad == `DTC_OFS_PACING) pace <= hwdata_i[2:0];
            since <= rd_cmd_go_o ? 6'h00 : (since == 6'h3F ? since : since + 6'h01);
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    ready_okay_a: assert property (hreadyout_o && !hresp_o) else $error("bus not ready or okay");
    rdata_idle_a: assert property (!dp_rd |-> hrdata_o == `DTC_WORD_ZERO)
        else $error("read data outside data phase");
    error_reevaluate_cause_a: assert property (err_error_reevaluate_pulse_o |-> $past(wr_cmd))
        else $error("evaluate pulse without command");
    error_reevaluate_single_a: assert property (err_error_reevaluate_pulse_o |=> !err_error_reevaluate_pulse_o)
        else $error("evaluate pulse too long");
    go_req_a: assert property (rd_cmd_go_o |-> $past(rd_cmd_req_i))
        else $error("read command without request");
    go_spacing_a: assert property (rd_cmd_go_o |-> since >= held - 6'h01)
        else $error("read commands too close");
    go_prompt_a: assert property (rd_cmd_req_i && since == 6'h3F |=> rd_cmd_go_o)
        else $error("idle request not served");
    irq_fall_a: assert property ($fell(err_irq_o) |-> $past(wr_irq, 2))
        else $error("interrupt dropped without clear");

    cover property (err_error_reevaluate_pulse_o);
    cover property (rd_cmd_go_o && pace == 3'h4);
    cover property ($fell(err_irq_o));
endmodule

bind dtc_top dtc_top_monitor mon (.clk_i, .arst_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
    .hready_i, .hwdata_i, .hrdata_o, .hreadyout_o, .hresp_o, .rd_cmd_req_i, .rd_cmd_go_o,
    .err_irq_o, .err_error_reevaluate_pulse_o);

/* File: dv/dtc_xfer_model.sv */
`timescale 1ns/1ps

// ----------------------------------------
// transfer side: status buses and read requester
// ----------------------------------------
module dtc_xfer_model (
    input  wire logic       clk_i,
    input  wire logic       go_i,
    output logic            req_o,
    output logic [3:0]      rd_status_o,
    output logic [7:0]      rd_opt_o,
    output logic [3:0]      wr_status_o,
    output logic [7:0]      wr_opt_o
);
    logic go_s;

    initial begin
        req_o = 1'b0;
        {rd_status_o, wr_status_o} = 8'h00;
        {rd_opt_o, wr_opt_o} = 16'h0000;
    end

    always @(negedge clk_i) go_s = go_i;

    // one-cycle status report, options {chain, irq, code}; options scramble after
    task fault(input logic [3:0] rs, input logic [3:0] ws, input logic [7:0] ro,
               input logic [7:0] wo);
        rd_status_o <= rs;
        wr_status_o <= ws;
        rd_opt_o <= ro;
        wr_opt_o <= wo;
        @(posedge clk_i);
        {rd_status_o, wr_status_o} <= 8'h00;
        rd_opt_o <= ~ro;
        wr_opt_o <= ~wo;
    endtask

    // hold request until k commands issued, report min and max spacing
    task reads(input int k, output int gmin, output int gmax);
        int c, last, seen;
        c = 0;
        last = 0;
        seen = 0;
        gmin = 999;
        gmax = 0;
        req_o <= 1'b1;
        while (seen < k && c < 400) begin
            @(posedge clk_i);
            c++;
            if (go_s === 1'b1) begin
                if (seen > 0 && c - last < gmin) gmin = c - last;
                if (seen > 0 && c - last > gmax) gmax = c - last;
                last = c;
                seen++;
                if (seen == k) req_o <= 1'b0;
            end
        end
        @(posedge clk_i);
    endtask
endmodule

/* File: dv/test_dtc_tc_error_detail_read_pacing.sv */
`timescale 1ns/1ps
`include "dtc_defs.svh"

module test_dma_tc_error_detail_read_pacing;
    logic        clk_i = 1'b0;
    logic        arst_n_i = 1'b0;
    logic        hsel = 1'b0, hwrite = 1'b0, rfault = 1'b0;
    logic [1:0]  htrans = 2'b00;
    logic [31:0] haddr = `DTC_WORD_ZERO, hwdata = `DTC_WORD_ZERO;
    logic [31:0] hrdata, rd_s, q, det;
    logic [3:0]  rs, ws;
    logic [7:0]  ro, wo;
    logic        hready, rdy_s, go, req, irq, error_reevaluate, error_reevaluate_s, irq_s;
    int          errors = 0, compares = 0, n;

    always #10 clk_i = ~clk_i;

    always @(negedge clk_i) begin
        rdy_s = hready;
        rd_s = hrdata;
        error_reevaluate_s = error_reevaluate;
        irq_s = irq;
    end

    dtc_top dut (.clk_i, .arst_n_i, .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(3'h2), .hready_i(hready), .hwdata_i(hwdata),
        .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(), .rd_status_i(rs),
        .rd_tcc_i(ro[5:0]), .rd_irq_en_i(ro[6]), .rd_chain_en_i(ro[7]), .wr_status_i(ws),
        .wr_tcc_i(wo[5:0]), .wr_irq_en_i(wo[6]), .wr_chain_en_i(wo[7]),
        .request_fault_i(rfault), .rd_cmd_req_i(req), .rd_cmd_go_o(go), .err_irq_o(irq),
        .err_error_reevaluate_pulse_o(error_reevaluate));

    dtc_xfer_model xfer (.clk_i, .go_i(go), .req_o(req), .rd_status_o(rs), .rd_opt_o(ro),
        .wr_status_o(ws), .wr_opt_o(wo));

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task wrap_up;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task wait_rdy;
        int k;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (rdy_s !== 1'b1 && k < 50);
        if (k >= 50) begin
            errors++;
            wrap_up;
        end
    endtask

    task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {20'h0_0000, a};
        wait_rdy;
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy;
        q = rd_s;
    endtask

    task one_cap(input logic [3:0] r, input logic [3:0] w, input logic [7:0] o,
                 input logic [7:0] p);
        if (w != 4'h0) det = {14'h0000, p[7:6], 2'b00, p[5:0], 4'h0, w};
        else det = {14'h0000, o[7:6], 2'b00, o[5:0], 4'h0, r};
        xfer.fault(r, w, o, p);
        bus(1'b0, `DTC_OFS_DETAIL, `DTC_WORD_ZERO);
        chk("detail", det, q);
    endtask

    task pulses(input int exp);
        n = 0;
        repeat (4) begin
            @(posedge clk_i);
            n += (error_reevaluate_s === 1'b1);
        end
        chk("error_reevaluate pulses", 32'(exp), 32'(n));
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_reset;
        chk("irq", `DTC_WORD_ZERO, 32'(irq_s));
        bus(1'b1, `DTC_OFS_DETAIL, 32'hFFFF_FFFF);
        bus(1'b0, `DTC_OFS_DETAIL, `DTC_WORD_ZERO);
        chk("detail", `DTC_WORD_ZERO, q);
        bus(1'b0, `DTC_OFS_PACING, `DTC_WORD_ZERO);
        chk("pacing", `DTC_WORD_ZERO, q);
        $display("t_reset done");
    endtask

    task t_capture;
        one_cap(4'h3, 4'h0, 8'hAA, 8'h55);
        one_cap(4'h0, 4'h9, 8'h3F, 8'h7F);
        one_cap(4'h5, 4'hA, 8'hC1, 8'h40);
        one_cap(4'h7, 4'hF, 8'h00, 8'hBE);
        $display("t_capture done");
    endtask

    task t_irq;
        bus(1'b0, `DTC_OFS_STATUS, `DTC_WORD_ZERO);
        chk("status", 32'h0000_0001, q);
        chk("irq masked", `DTC_WORD_ZERO, 32'(irq_s));
        bus(1'b1, `DTC_OFS_ENABLE, 32'h0000_000D);
        repeat (2) @(posedge clk_i);
        chk("irq", 32'h0000_0001, 32'(irq_s));
        bus(1'b0, 12'h020, `DTC_WORD_ZERO);
        bus(1'b0, `DTC_OFS_STATUS, `DTC_WORD_ZERO);
        chk("status", 32'h0000_0009, q);
        bus(1'b1, `DTC_OFS_CLEAR, 32'h0000_0008);
        bus(1'b0, `DTC_OFS_DETAIL, `DTC_WORD_ZERO);
        chk("detail", det, q);
        rfault <= 1'b1;
        @(posedge clk_i);
        rfault <= 1'b0;
        bus(1'b1, `DTC_OFS_CLEAR, 32'h0000_0004);
        bus(1'b0, `DTC_OFS_DETAIL, `DTC_WORD_ZERO);
        chk("detail", det, q);
        bus(1'b1, `DTC_OFS_CLEAR, 32'h0000_0001);
        bus(1'b0, `DTC_OFS_DETAIL, `DTC_WORD_ZERO);
        chk("detail", `DTC_WORD_ZERO, q);
        bus(1'b0, `DTC_OFS_STATUS, `DTC_WORD_ZERO);
        chk("status", `DTC_WORD_ZERO, q);
        chk("irq", `DTC_WORD_ZERO, 32'(irq_s));
        $display("t_irq done");
    endtask

    task t_error_reevaluate;
        xfer.fault(4'h2, 4'h0, 8'h01, 8'h02);
        bus(1'b1, `DTC_OFS_COMMAND, `DTC_WORD_ZERO);
        pulses(0);
        bus(1'b1, `DTC_OFS_COMMAND, 32'h0000_0001);
        pulses(1);
        bus(1'b1, `DTC_OFS_CLEAR, 32'h0000_0001);
        bus(1'b1, `DTC_OFS_COMMAND, 32'h0000_0001);
        pulses(0);
        $display("t_error_reevaluate done");
    endtask

    task t_pace;
        int gmin, gmax, g;
        for (int r = 0; r < 5; r++) begin
            g = (r == 0) ? 1 : 4 << (r - 1);
            bus(1'b1, `DTC_OFS_PACING, 32'(r));
            bus(1'b0, `DTC_OFS_PACING, `DTC_WORD_ZERO);
            chk("pacing", 32'(r), q);
            xfer.reads(4, gmin, gmax);
            chk("gap min", 32'(g), 32'(gmin));
            chk("gap max", 32'(g), 32'(gmax));
            xfer.reads(3, gmin, gmax);
            chk("next request gap", 32'(g), 32'(gmin));
        end
        $display("t_pace done");
    endtask

    initial begin
        repeat (2) @(posedge clk_i);
        arst_n_i <= 1'b1;
        @(posedge clk_i);
        t_reset;
        t_capture;
        t_irq;
        t_error_reevaluate;
        t_pace;
        wrap_up;
    end
endmodule
